// [logic/gpio_pkg.sv]
// Register map, field layout and bus constants for the pin control block
package gpio_pkg;

	// Register indexes; byte address is four times the index
	localparam logic [7:0] IDX_P57_CFG = 8'h46;
	localparam logic [7:0] IDX_P60_CFG = 8'h47;
	localparam logic [7:0] IDX_P61_CFG = 8'h48;
	localparam logic [7:0] IDX_RSVD_A = 8'h49;
	localparam logic [7:0] IDX_RSVD_B = 8'h4A;
	localparam logic [7:0] IDX_P1_DATA = 8'h4B;
	localparam logic [7:0] IDX_P2_DATA = 8'h4C;
	localparam logic [7:0] IDX_P3_DATA = 8'h4D;
	localparam logic [7:0] IDX_P4_DATA = 8'h4E;
	localparam logic [7:0] IDX_PIN_DATA = 8'h55;
	localparam logic [7:0] IDX_STATUS = 8'h56;
	localparam logic [7:0] IDX_MASK = 8'h57;

	// Configured pins: port 5 pin 7, port 6 pin 0, port 6 pin 1
	localparam int NPINS = 3;
	localparam logic [7:0] CFG_IDX [NPINS] = '{8'h46, 8'h47, 8'h48};
	// Pins that may act as either-edge interrupt inputs
	localparam logic [NPINS-1:0] IRQ_CAPABLE = 3'h6;

	// Reset values and writable bit masks
	localparam logic [7:0] CFG_RESET = 8'h01;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [7:0] CFG_WMASK = 8'h8F;
	localparam logic [7:0] P2_WMASK = 8'hF7;
	localparam logic [7:0] P3_HARD_KEEP = 8'hF3;
	localparam logic [NPINS-1:0] PINS_RESET = 3'h0;

	// Configuration field positions
	localparam int CFG_DIR = 0;
	localparam int CFG_POL = 1;
	localparam int CFG_FN_LO = 2;
	localparam int CFG_FN_HI = 3;
	localparam int CFG_OD = 7;

	// Function select codes
	localparam logic [1:0] FN_GPIO = 2'h0;
	localparam logic [1:0] FN_ALT = 2'h1;
	localparam logic [1:0] FN_IRQ = 2'h2;

	// Bus fields
	localparam int ADDR_IDX_LO = 2;
	localparam int ADDR_IDX_HI = 9;
	localparam int TRANS_ACTIVE = 1;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b00,
		BUS_WRITE = 2'b01,
		BUS_READ = 2'b10,
		BUS_READY = 2'b11
	} busState_t;

endpackage

// [logic/gpio_pin_regs.sv]
// Pin configuration and port data registers behind an AHB-Lite slave
`timescale 1ns/1ps

module gpio_pin_regs (
	input wire logic clk,
	input wire logic nrst,
	input wire logic hardRstN,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic irq,
	input wire logic serial2_terminal_ready_out,
	input wire logic indicator_out_a,
	input wire logic indicator_out_b,
	input wire logic [gpio_pkg::NPINS-1:0] pinIn,
	output logic [gpio_pkg::NPINS-1:0] pinOut,
	output logic [gpio_pkg::NPINS-1:0] pinOe,
	output logic [7:0] port1_data,
	output logic [7:0] port2_data,
	output logic [7:0] port3_data,
	output logic [7:0] port4_data
);

	logic rstMeta;
	logic rstN;
	gpio_pkg::busState_t busState;
	logic [7:0] dpIndex;
	logic [7:0] readVal;
	logic [7:0] cfgReg [gpio_pkg::NPINS];
	logic [gpio_pkg::NPINS-1:0] pinData;
	logic [gpio_pkg::NPINS-1:0] pinSample;
	logic [gpio_pkg::NPINS-1:0] pinPrev;
	logic [gpio_pkg::NPINS-1:0] pinLevel;
	logic [gpio_pkg::NPINS-1:0] pinReadBack;
	logic [gpio_pkg::NPINS-1:0] altOut;
	logic [gpio_pkg::NPINS-1:0] pinEvent;
	logic [gpio_pkg::NPINS-1:0] intStatus;
	logic [gpio_pkg::NPINS-1:0] intMask;
	logic accept;
	logic wrStrobe;
	logic rdFetch;
	logic [7:0] wrByte;

	// Reset release through two flops
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rstMeta <= 1'b0;
			rstN <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstN <= rstMeta;
		end
	end

	default clocking defClk @(posedge clk);
	endclocking
	default disable iff (!rstN);

	// Bus handshake: reads take one wait state, writes none
	assign accept = hsel && htrans[gpio_pkg::TRANS_ACTIVE] && hready;
	assign hreadyout = (busState != gpio_pkg::BUS_READ);
	assign hresp = gpio_pkg::HRESP_OKAY;
	assign wrStrobe = (busState == gpio_pkg::BUS_WRITE);
	assign rdFetch = (busState == gpio_pkg::BUS_READ);
	assign wrByte = hwdata[7:0];

	// Bus phase tracking
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			busState <= gpio_pkg::BUS_IDLE;
			dpIndex <= 8'h00;
		end else begin
			case (busState)
				gpio_pkg::BUS_READ: begin
					busState <= gpio_pkg::BUS_READY;
				end
				default: begin
					if (accept && hwrite) begin
						busState <= gpio_pkg::BUS_WRITE;
					end else if (accept) begin
						busState <= gpio_pkg::BUS_READ;
					end else begin
						busState <= gpio_pkg::BUS_IDLE;
					end
					if (accept) begin
						dpIndex <= haddr[gpio_pkg::ADDR_IDX_HI:gpio_pkg::ADDR_IDX_LO];
					end
				end
			endcase
		end
	end

	// Alternate output sources per pin
	assign altOut = {indicator_out_b, indicator_out_a,
		serial2_terminal_ready_out};

	// Per-pin driver, polarity and edge detection
	for (genvar i = 0; i < gpio_pkg::NPINS; i++) begin : gPin
		logic [1:0] fn;
		logic drives;
		logic isIrq;
		logic level;
		assign fn = cfgReg[i][gpio_pkg::CFG_FN_HI:gpio_pkg::CFG_FN_LO];
		// Reserved codes leave the pin undriven
		assign isIrq = gpio_pkg::IRQ_CAPABLE[i] && (fn == gpio_pkg::FN_IRQ);
		assign drives = (fn == gpio_pkg::FN_ALT) ||
			((fn == gpio_pkg::FN_GPIO) && !cfgReg[i][gpio_pkg::CFG_DIR]);
		assign level = ((fn == gpio_pkg::FN_ALT) ? altOut[i] : pinData[i]) ^
			cfgReg[i][gpio_pkg::CFG_POL];
		assign pinLevel[i] = level;
		// Open drain only pulls low
		assign pinOut[i] = cfgReg[i][gpio_pkg::CFG_OD] ? 1'b0 : level;
		assign pinOe[i] = drives && (!cfgReg[i][gpio_pkg::CFG_OD] || !level);
		assign pinReadBack[i] = drives ? pinData[i] :
			(pinSample[i] ^ cfgReg[i][gpio_pkg::CFG_POL]);
		assign pinEvent[i] = isIrq && (pinSample[i] != pinPrev[i]);

		// Configuration register write
		always_ff @(posedge clk or negedge rstN) begin
			if (!rstN) begin
				cfgReg[i] <= gpio_pkg::CFG_RESET;
			end else if (wrStrobe && dpIndex == gpio_pkg::CFG_IDX[i]) begin
				cfgReg[i] <= wrByte & gpio_pkg::CFG_WMASK;
			end
		end
	end

	// Pin level sampling for edge detection
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pinSample <= gpio_pkg::PINS_RESET;
			pinPrev <= gpio_pkg::PINS_RESET;
		end else begin
			pinSample <= pinIn;
			pinPrev <= pinSample;
		end
	end

	// Output data latch of the configured pins
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			pinData <= gpio_pkg::PINS_RESET;
		end else if (wrStrobe && dpIndex == gpio_pkg::IDX_PIN_DATA) begin
			pinData <= wrByte[gpio_pkg::NPINS-1:0];
		end
	end

	// Port 1 and port 4 data registers
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			port1_data <= gpio_pkg::DATA_RESET;
			port4_data <= gpio_pkg::DATA_RESET;
		end else if (wrStrobe && dpIndex == gpio_pkg::IDX_P1_DATA) begin
			port1_data <= wrByte;
		end else if (wrStrobe && dpIndex == gpio_pkg::IDX_P4_DATA) begin
			port4_data <= wrByte;
		end
	end

	// Port 2 data register, reserved bit held at zero
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			port2_data <= gpio_pkg::DATA_RESET;
		end else if (wrStrobe && dpIndex == gpio_pkg::IDX_P2_DATA) begin
			port2_data <= wrByte & gpio_pkg::P2_WMASK;
		end
	end

	// Port 3 data register; hard reset wins over a write
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			port3_data <= gpio_pkg::DATA_RESET;
		end else if (!hardRstN) begin
			port3_data <= port3_data & gpio_pkg::P3_HARD_KEEP;
		end else if (wrStrobe && dpIndex == gpio_pkg::IDX_P3_DATA) begin
			port3_data <= wrByte;
		end
	end

	// Sticky edge status; new event wins over read clear
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			intStatus <= gpio_pkg::PINS_RESET;
		end else if (rdFetch && dpIndex == gpio_pkg::IDX_STATUS) begin
			intStatus <= pinEvent;
		end else begin
			intStatus <= intStatus | pinEvent;
		end
	end

	// Interrupt mask register
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			intMask <= gpio_pkg::PINS_RESET;
		end else if (wrStrobe && dpIndex == gpio_pkg::IDX_MASK) begin
			intMask <= wrByte[gpio_pkg::NPINS-1:0];
		end
	end

	// Level interrupt from unmasked status
	assign irq = |(intStatus & intMask);

	// Read data selection; reserved and unmapped read zero
	always_comb begin
		readVal = 8'h00;
		if (dpIndex == gpio_pkg::IDX_P57_CFG) begin
			readVal = cfgReg[0];
		end else if (dpIndex == gpio_pkg::IDX_P60_CFG) begin
			readVal = cfgReg[1];
		end else if (dpIndex == gpio_pkg::IDX_P61_CFG) begin
			readVal = cfgReg[2];
		end else if (dpIndex == gpio_pkg::IDX_RSVD_A) begin
			readVal = 8'h00;
		end else if (dpIndex == gpio_pkg::IDX_RSVD_B) begin
			readVal = 8'h00;
		end else if (dpIndex == gpio_pkg::IDX_P1_DATA) begin
			readVal = port1_data;
		end else if (dpIndex == gpio_pkg::IDX_P2_DATA) begin
			readVal = port2_data;
		end else if (dpIndex == gpio_pkg::IDX_P3_DATA) begin
			readVal = port3_data;
		end else if (dpIndex == gpio_pkg::IDX_P4_DATA) begin
			readVal = port4_data;
		end else if (dpIndex == gpio_pkg::IDX_PIN_DATA) begin
			readVal = {5'h00, pinReadBack};
		end else if (dpIndex == gpio_pkg::IDX_STATUS) begin
			readVal = {5'h00, intStatus};
		end else if (dpIndex == gpio_pkg::IDX_MASK) begin
			readVal = {5'h00, intMask};
		end
	end

	// Read data register, loaded in the wait cycle
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			hrdata <= 32'h0000_0000;
		end else if (rdFetch) begin
			hrdata <= {24'h00_0000, readVal};
		end
	end

	// Input direction with the GPIO function never drives
	dirInput_a: assert property (
		cfgReg[0][gpio_pkg::CFG_DIR] &&
		cfgReg[0][gpio_pkg::CFG_FN_HI:gpio_pkg::CFG_FN_LO] ==
		gpio_pkg::FN_GPIO |-> !pinOe[0])
		else $error("input pin is driven");

	// Push-pull GPIO output follows data through polarity
	polarityOut_a: assert property (
		cfgReg[0] == 8'h02 |-> pinOe[0] && pinOut[0] == !pinData[0])
		else $error("inverted output mismatch");

	// Reserved function leaves pin undriven
	reservedFn_a: assert property (
		cfgReg[2][gpio_pkg::CFG_FN_HI:gpio_pkg::CFG_FN_LO] == 2'h3
		|-> !pinOe[2])
		else $error("reserved function drives pin");

	// Terminal-ready routed to port 5 pin 7
	dtrRoute_a: assert property (
		cfgReg[0] == 8'h04 |-> pinOe[0] &&
		pinOut[0] == serial2_terminal_ready_out)
		else $error("terminal ready not routed");

	// Edge on port 6 pin 0 sets its status next cycle
	edgeIrqA_a: assert property (
		cfgReg[1][gpio_pkg::CFG_FN_HI:gpio_pkg::CFG_FN_LO] ==
		gpio_pkg::FN_IRQ && $changed(pinSample[1]) |=> intStatus[1])
		else $error("port 6 pin 0 edge lost");

	// Edge on port 6 pin 1 sets its status next cycle
	edgeIrqB_a: assert property (
		cfgReg[2][gpio_pkg::CFG_FN_HI:gpio_pkg::CFG_FN_LO] ==
		gpio_pkg::FN_IRQ && $changed(pinSample[2]) |=> intStatus[2])
		else $error("port 6 pin 1 edge lost");

	// Open drain output never drives high, pulls low for a low level
	openDrain_a: assert property (
		cfgReg[0][gpio_pkg::CFG_OD] && !cfgReg[0][gpio_pkg::CFG_DIR] &&
		cfgReg[0][gpio_pkg::CFG_FN_HI:gpio_pkg::CFG_FN_LO] ==
		gpio_pkg::FN_GPIO |-> !pinOut[0] && pinOe[0] == !pinLevel[0])
		else $error("open drain drove high");

	// Reserved slots return zero
	rsvdRead_a: assert property (
		rdFetch && (dpIndex == gpio_pkg::IDX_RSVD_A ||
		dpIndex == gpio_pkg::IDX_RSVD_B) |=> hreadyout && hrdata == 32'h0)
		else $error("reserved slot read nonzero");

	// Hard reset clears port 3 bits 2 and 3
	hardClear_a: assert property (
		!hardRstN |=> (port3_data & ~gpio_pkg::P3_HARD_KEEP) == 8'h00)
		else $error("port 3 bits not cleared");

	// Port 2 bit 3 stays zero
	port2Rsvd_a: assert property (
		wrStrobe && dpIndex == gpio_pkg::IDX_P2_DATA |=>
		port2_data == ($past(hwdata[7:0]) & gpio_pkg::P2_WMASK))
		else $error("port 2 write wrong");

	// Config write keeps only the defined fields
	cfgWrite_a: assert property (
		wrStrobe && dpIndex == gpio_pkg::IDX_P57_CFG |=>
		cfgReg[0] == ($past(wrByte) & gpio_pkg::CFG_WMASK))
		else $error("config write wrong");

	// Port 1 takes the whole written byte
	port1Write_a: assert property (
		wrStrobe && dpIndex == gpio_pkg::IDX_P1_DATA |=>
		port1_data == $past(wrByte))
		else $error("port 1 write wrong");

	// Port 4 takes the whole written byte
	port4Write_a: assert property (
		wrStrobe && dpIndex == gpio_pkg::IDX_P4_DATA |=>
		port4_data == $past(wrByte))
		else $error("port 4 write wrong");

	// Port 3 takes a write while hard reset is idle
	port3Write_a: assert property (
		wrStrobe && dpIndex == gpio_pkg::IDX_P3_DATA && hardRstN |=>
		port3_data == $past(wrByte))
		else $error("port 3 write wrong");

	// Hard reset leaves the other port 3 bits alone
	hardKeep_a: assert property (
		!hardRstN |=> (port3_data & gpio_pkg::P3_HARD_KEEP) ==
		($past(port3_data) & gpio_pkg::P3_HARD_KEEP))
		else $error("port 3 bits disturbed");

	// Indicator A routed to port 6 pin 0
	ledRouteA_a: assert property (
		cfgReg[1] == 8'h04 |-> pinOe[1] &&
		pinOut[1] == indicator_out_a)
		else $error("indicator A not routed");

	// Indicator B routed to port 6 pin 1
	ledRouteB_a: assert property (
		cfgReg[2] == 8'h04 |-> pinOe[2] &&
		pinOut[2] == indicator_out_b)
		else $error("indicator B not routed");

	// Plain input reads back the sampled pin level
	inputRead_a: assert property (
		rdFetch && dpIndex == gpio_pkg::IDX_PIN_DATA &&
		cfgReg[0] == 8'h01
		|=> hrdata[0] == $past(pinSample[0]))
		else $error("input read-back wrong");

	// Status read returns the pending bits and clears them
	statusRead_a: assert property (
		rdFetch && dpIndex == gpio_pkg::IDX_STATUS |=>
		hrdata[gpio_pkg::NPINS-1:0] == $past(intStatus) &&
		intStatus == $past(pinEvent))
		else $error("status read wrong");

endmodule // gpio_pin_regs

// [verif/pin_partner.sv]
// Far side of the three configurable pins: wire resolution per pin
`timescale 1ns/1ps

module pin_partner (
	input wire logic [2:0] pinOut,
	input wire logic [2:0] pinOe,
	input wire logic [2:0] extLevel,
	output logic [2:0] pinIn
);
	// Driven pins follow the device, released pins the far side
	assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule // pin_partner

// [verif/tb_top.sv]
// Self-checking bench for the pin control and port data registers
`timescale 1ns/1ps

module tb_top;
	logic clk, nrst, hardRstN, hsel, hwrite, irq, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize, alt, ext, pinIn, pinOut, pinOe;
	logic [7:0] p1, p2, p3, p4;
	int n_errors, checks_done;

	gpio_pin_regs u_dut (.clk(clk), .nrst(nrst), .hardRstN(hardRstN),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
		.serial2_terminal_ready_out(alt[0]), .indicator_out_a(alt[1]),
		.indicator_out_b(alt[2]), .pinIn(pinIn), .pinOut(pinOut),
		.pinOe(pinOe), .port1_data(p1), .port2_data(p2), .port3_data(p3),
		.port4_data(p4));

	pin_partner u_pins (.pinOut(pinOut), .pinOe(pinOe), .extLevel(ext),
		.pinIn(pinIn));

	// Clock of 100 ns period
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic fail(input string m);
		n_errors++;
		$display("ERROR %0t %s", $time, m);
	endtask

	task automatic checkVal(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fail($sformatf("got %h expected %h", got, exp));
		end
	endtask

	// Waits for ready sampled high, takes read data at that edge
	task automatic waitRdy(output logic [31:0] d);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (hreadyout !== 1'b1 && n < 50);
		d = hrdata;
		if (n >= 50) begin
			fail("no ready");
		end
		@(posedge clk);
	endtask

	// Each transfer starts just after a rising edge, so the address
	// phase is never sampled twice when called between edges
	task automatic ahbWr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= 1'b1;
		haddr <= {22'h0, idx, 2'h0};
		waitRdy(rd);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		waitRdy(rd);
	endtask

	task automatic ahbRd(input logic [7:0] idx, output logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= 1'b0;
		haddr <= {22'h0, idx, 2'h0};
		waitRdy(d);
		hsel <= 1'b0;
		htrans <= 2'h0;
		waitRdy(d);
	endtask

	// Reset values, then reserved bits and slots after writing all ones
	task automatic tRegs;
		logic [7:0] ix [6] = '{8'h46, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4E};
		logic [7:0] ex [6] = '{8'h8F, 8'h00, 8'h00, 8'hFF, 8'hF7, 8'hFF};
		for (int i = 0; i < 9; i++) begin
			ahbRd(8'h46 + 8'(i), rd);
			checkVal(rd, (i < 3) ? 32'h1 : 32'h0);
		end
		for (int i = 0; i < 6; i++) begin
			ahbWr(ix[i], 8'hFF);
			ahbRd(ix[i], rd);
			checkVal(rd, {24'h0, ex[i]});
		end
		checkVal({7'h0, hresp, p1, p2, p4}, 32'hFFF7FF);
		$display("test regs done");
	endtask

	// Output drive with polarity and driver type
	task automatic tOut;
		ahbWr(8'h46, 8'h00);
		ahbWr(8'h55, 8'h01);
		@(negedge clk);
		checkVal({pinOe[0], pinOut[0]}, 32'h3);
		ahbWr(8'h46, 8'h02);
		@(negedge clk);
		checkVal({pinOe[0], pinOut[0]}, 32'h2);
		ahbWr(8'h46, 8'h80);
		@(negedge clk);
		checkVal({pinOe[0], pinOut[0]}, 32'h0);
		ahbWr(8'h55, 8'h00);
		@(negedge clk);
		checkVal({pinOe[0], pinOut[0]}, 32'h2);
		$display("test output done");
	endtask

	// Input read-back through polarity
	task automatic tIn;
		ext <= 3'h1;
		ahbWr(8'h46, 8'h01);
		ahbRd(8'h55, rd);
		checkVal(rd, 32'h1);
		ahbWr(8'h46, 8'h03);
		ahbRd(8'h55, rd);
		checkVal(rd, 32'h0);
		$display("test input done");
	endtask

	// Alternate sources, then interrupt code on port 5 pin 7 and reserved code on port 6 pin 1
	task automatic tAlt;
		alt <= 3'h7;
		for (int i = 0; i < 3; i++) begin
			ahbWr(8'h46 + 8'(i), 8'h04);
		end
		@(negedge clk);
		checkVal({pinOe, pinOut}, 32'h3F);
		alt <= 3'h0;
		ahbWr(8'h46, 8'h08);
		@(negedge clk);
		checkVal({pinOe, pinOut}, 32'h30);
		ahbWr(8'h48, 8'h0C);
		@(negedge clk);
		checkVal({pinOe, pinOut}, 32'h10);
		$display("test alternate done");
	endtask

	// Either-edge events on both interrupt pins, masking and clearing
	task automatic tIrq;
		ext <= 3'h0;
		ahbWr(8'h57, 8'h06);
		for (int i = 1; i < 3; i++) begin
			ahbWr(8'h46 + 8'(i), 8'h09);
			for (int e = 0; e < 2; e++) begin
				ext[i] <= ~ext[i];
				repeat (3) @(posedge clk);
				@(negedge clk);
				checkVal(irq, 32'h1);
				ahbRd(8'h56, rd);
				checkVal(rd, 32'h1 << i);
				@(negedge clk);
				checkVal(irq, 32'h0);
			end
		end
		ahbWr(8'h57, 8'h00);
		ext <= 3'h6;
		repeat (3) @(posedge clk);
		@(negedge clk);
		checkVal(irq, 32'h0);
		ahbRd(8'h56, rd);
		checkVal(rd, 32'h6);
		$display("test interrupt done");
	endtask

	// Hard reset clears only port 3 bits 2 and 3
	task automatic tHard;
		ahbWr(8'h4D, 8'hFF);
		hardRstN <= 1'b0;
		repeat (2) @(posedge clk);
		hardRstN <= 1'b1;
		ahbRd(8'h4D, rd);
		checkVal(rd, 32'hF3);
		checkVal(p3, 32'hF3);
		$display("test hard reset done");
	endtask

	task automatic summarize;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Watchdog well beyond the expected run of a few hundred cycles
	initial begin
		#2000000;
		fail("timeout");
		summarize();
	end

	// Main sequence
	initial begin
		{nrst, hsel, hwrite, haddr, hwdata, htrans, alt, ext} = '0;
		hardRstN = 1'b1;
		hsize = 3'h2;
		n_errors = 0;
		checks_done = 0;
		repeat (12) @(posedge clk);
		nrst <= 1'b1;
		repeat (4) @(posedge clk);
		tRegs();
		tOut();
		tIn();
		tAlt();
		tIrq();
		tHard();
		summarize();
	end
endmodule // tb_top
